// ---- design/mmbd_decoder.v ----
/*
 Memory map and boot decoder for a multi-master AHB matrix. Registers
 one decode per master per cycle: target slave, local offset, external
 chip select, and abort for unmapped space.
 Assumes masters present a new address each cycle with o_* valid one
 cycle later; SRAM and ROM answer in that cycle.
*/
// Functional notes
// - Sixteen 256 MB banks from address top
// - Banks one to six go to EBI; seven and eight abort
// - Bank zero holds 1 MB internal area
// - Bank fifteen goes to peripheral bridge
// - Unmapped region access returns abort
// - Lowest 1 MB reserved for boot alias
// - Remap clear, boot pin high: ROM
// - Remap clear, boot pin low: CS0
// - Per-master remap bit maps SRAM zero
// - SRAM base 0x00300000 before remap
// - Remapped zero SRAM only for CPU masters
// - Instruction TCM at 0x00100000 for AHB
// - Data TCM at 0x00200000 for AHB
// - TCM sizes 0/16/32 KB, rest AHB
// - Reset gives all blocks to AHB
// - Non-contiguous block allocation order
// - ROM always at 0x00400000
// - Own base always reachable
// - SRAM answers in one cycle
// - CS0 reset boot config 16-bit
// - 26 address bits per chip select
// - CS1 SDRAM or static controller
`timescale 1ns/10ps
`include "mmbd_regs.vh"

module mmbd_decoder #(
   parameter NUM_MASTERS = 6,
   parameter CPU_INSTR_MASTER = 4,
   parameter CPU_DATA_MASTER = 5
) (
   input wire i_core_clk,
   input wire i_resetn,
   input wire i_boot_select_pin,
   input wire [NUM_MASTERS-1:0] i_remap_set,
   input wire [NUM_MASTERS-1:0] i_remap_clr,
   input wire [1:0] i_itcm_size,
   input wire [1:0] i_dtcm_size,
   input wire i_cs1_sdram,
   input wire [NUM_MASTERS-1:0] i_valid,
   input wire [NUM_MASTERS*32-1:0] i_addr,
   output reg [NUM_MASTERS*3-1:0] o_sel,
   output reg [NUM_MASTERS*26-1:0] o_offset,
   output reg [NUM_MASTERS*3-1:0] o_cs,
   output reg [NUM_MASTERS*2-1:0] o_sram_blk,
   output reg [NUM_MASTERS-1:0] o_sdram_cs,
   output reg [NUM_MASTERS-1:0] o_abort,
   output reg [NUM_MASTERS-1:0] o_ready,
   output reg [NUM_MASTERS-1:0] o_master_remap_bit,
   output reg o_boot_rom,
   output reg [1:0] o_itcm_size,
   output reg [1:0] o_dtcm_size,
   output reg o_cs0_byte_sel,
   output reg o_cs0_width16,
   output reg o_cs0_rw_by_cs
);
   reg rst_s1_q;
   reg rst_s2_q;
   wire rstn = rst_s2_q;

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // Boot pin through three stages; latched once after release
   localparam [1:0] BOOT_FILL = 2'h0;
   localparam [1:0] BOOT_SETTLE = 2'h1;
   localparam [1:0] BOOT_HELD = 2'h2;
   reg bp_s1_q;
   reg bp_s2_q;
   reg bp_s3_q;
   reg [1:0] boot_st_q;
   reg [1:0] boot_st_d;
   reg [1:0] fill_q;
   reg [1:0] fill_d;
   reg boot_rom_q;
   reg boot_rom_d;

   // Stages hold reset zeros at first, so wait until all three have
   // seen the pin before their agreement is trusted
   always @* begin
      boot_st_d = boot_st_q;
      fill_d = fill_q;
      boot_rom_d = boot_rom_q;
      case (boot_st_q)
         BOOT_FILL: begin
            fill_d = fill_q + 2'h1;
            if (fill_q == 2'h2)
               boot_st_d = BOOT_SETTLE;
         end
         BOOT_SETTLE: begin
            if (bp_s2_q == bp_s3_q) begin
               boot_rom_d = bp_s3_q;
               boot_st_d = BOOT_HELD;
            end
         end
         BOOT_HELD: begin
            boot_st_d = BOOT_HELD;
         end
         default: begin
            boot_st_d = BOOT_FILL;
         end
      endcase
   end

   always @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         bp_s1_q <= 1'b0;
         bp_s2_q <= 1'b0;
         bp_s3_q <= 1'b0;
         boot_st_q <= BOOT_FILL;
         fill_q <= 2'h0;
         boot_rom_q <= 1'b0;
      end else begin
         bp_s1_q <= i_boot_select_pin;
         bp_s2_q <= bp_s1_q;
         bp_s3_q <= bp_s2_q;
         boot_st_q <= boot_st_d;
         fill_q <= fill_d;
         boot_rom_q <= boot_rom_d;
      end
   end

   // Remap bits; set wins over clear
   // A clear racing a set keeps the bit, so no remap is lost
   reg [NUM_MASTERS-1:0] remap_q;
   always @(posedge i_core_clk or negedge rstn) begin
      if (!rstn)
         remap_q <= {NUM_MASTERS{1'b0}};
      else
         remap_q <= (remap_q & ~i_remap_clr) | i_remap_set;
   end

   // TCM size, illegal code treated as zero
   // Decode reads these copies, so a size change lands a cycle late
   reg [1:0] itcm_q;
   reg [1:0] dtcm_q;
   always @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         itcm_q <= `MMBD_TCM_RESET;
         dtcm_q <= `MMBD_TCM_RESET;
      end else begin
         itcm_q <= (i_itcm_size > `MMBD_TCM_32K) ? `MMBD_TCM_0K
                   : i_itcm_size;
         dtcm_q <= (i_dtcm_size > `MMBD_TCM_32K) ? `MMBD_TCM_0K
                   : i_dtcm_size;
      end
   end

   always @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         o_master_remap_bit <= {NUM_MASTERS{1'b0}};
         o_boot_rom <= 1'b0;
         o_itcm_size <= `MMBD_TCM_RESET;
         o_dtcm_size <= `MMBD_TCM_RESET;
         o_cs0_byte_sel <= `MMBD_CS0_BYTE_SEL_RST;
         o_cs0_width16 <= `MMBD_CS0_WIDTH16_RST;
         o_cs0_rw_by_cs <= `MMBD_CS0_RW_BY_CS_RST;
      end else begin
         o_master_remap_bit <= remap_q;
         o_boot_rom <= boot_rom_q;
         o_itcm_size <= itcm_q;
         o_dtcm_size <= dtcm_q;
         // Boot setup for chip select 0 is fixed; tuning lives elsewhere
         o_cs0_byte_sel <= `MMBD_CS0_BYTE_SEL_RST;
         o_cs0_width16 <= `MMBD_CS0_WIDTH16_RST;
         o_cs0_rw_by_cs <= `MMBD_CS0_RW_BY_CS_RST;
      end
   end

   genvar m;
   generate
      for (m = 0; m < NUM_MASTERS; m = m + 1) begin : g_master
         wire [31:0] a = i_addr[m*32 +: 32];
         wire [3:0] bank = a[`MMBD_BANK_MSB:`MMBD_BANK_LSB];
         wire [7:0] area = a[`MMBD_AREA_MSB:`MMBD_AREA_LSB];
         wire [1:0] blk = a[`MMBD_BLK_MSB:`MMBD_BLK_LSB];
         wire is_cpu = (m == CPU_INSTR_MASTER) || (m == CPU_DATA_MASTER);
         // Offset above the 4th block is out of the 64 KB SRAM
         wire in64k = (a[19:16] == 4'h0);
         reg [1:0] map_area;
         wire map_hit;
         wire [1:0] map_phys;
         reg [2:0] sel_d;
         reg [25:0] off_d;
         reg [2:0] cs_d;
         reg abort_d;
         reg sdram_d;

         // One mapper per master keeps the decodes independent
         mmbd_sram_map u_map (
            .i_itcm_size(itcm_q),
            .i_dtcm_size(dtcm_q),
            .i_area(map_area),
            .i_blk(blk),
            .o_hit(map_hit),
            .o_phys(map_phys)
         );

         always @* begin
            sel_d = `MMBD_SEL_NONE;
            off_d = a[25:0];
            cs_d = 3'h0;
            abort_d = 1'b0;
            sdram_d = 1'b0;
            map_area = 2'h0;
            if (bank == `MMBD_BANK_INT) begin
               case (area)
                  `MMBD_AREA_BOOT: begin
                     if (remap_q[m]) begin
                        // Alias of the AHB SRAM partition
                        map_area = 2'h3;
                        if (is_cpu && in64k && map_hit)
                           sel_d = `MMBD_SEL_SRAM;
                        else
                           abort_d = 1'b1;
                     end else if (boot_rom_q) begin
                        sel_d = `MMBD_SEL_ROM;
                        off_d = {11'h000, a[`MMBD_ROM_BITS-1:0]};
                     end else begin
                        // External alias spans the whole 1 MB region
                        sel_d = `MMBD_SEL_EBI;
                        cs_d = 3'h0;
                        off_d = {6'h00, a[19:0]};
                     end
                  end
                  `MMBD_AREA_ITCM,
                  `MMBD_AREA_DTCM,
                  `MMBD_AREA_SRAMC: begin
                     map_area = area[1:0];
                     if ((m != CPU_INSTR_MASTER || area == `MMBD_AREA_SRAMC)
                         && in64k && map_hit)
                        sel_d = `MMBD_SEL_SRAM;
                     else
                        abort_d = 1'b1;
                  end
                  `MMBD_AREA_ROM: begin
                     // 32 KB of ROM; the rest of its 1 MB area aborts
                     if (a[19:`MMBD_ROM_BITS] == 5'h00) begin
                        sel_d = `MMBD_SEL_ROM;
                        off_d = {11'h000, a[`MMBD_ROM_BITS-1:0]};
                     end else
                        abort_d = 1'b1;
                  end
                  default: abort_d = 1'b1;
               endcase
               if (sel_d == `MMBD_SEL_SRAM)
                  off_d = {10'h000, map_phys, a[`MMBD_BLK_BITS-1:0]};
            end else if (bank >= `MMBD_BANK_EBI_LO &&
                         bank <= `MMBD_BANK_EBI_HI) begin
               // Banks 7 and 8 give chip selects 6 and 7, which do not exist
               cs_d = bank[2:0] - 3'h1;
               if (cs_d < `MMBD_EBI_CS_NUM) begin
                  sel_d = `MMBD_SEL_EBI;
                  off_d = a[`MMBD_EBI_ADDR_BITS-1:0];
                  sdram_d = (cs_d == 3'h1) && i_cs1_sdram;
               end else
                  abort_d = 1'b1;
            end else if (bank == `MMBD_BANK_APB) begin
               sel_d = `MMBD_SEL_APB;
            end else
               abort_d = 1'b1;
            // Idle masters show no select, abort or ready
            if (!i_valid[m]) begin
               sel_d = `MMBD_SEL_NONE;
               abort_d = 1'b0;
               sdram_d = 1'b0;
            end
         end

         always @(posedge i_core_clk or negedge rstn) begin
            if (!rstn) begin
               o_sel[m*3 +: 3] <= `MMBD_SEL_NONE;
               o_offset[m*26 +: 26] <= 26'h0000000;
               o_cs[m*3 +: 3] <= 3'h0;
               o_sram_blk[m*2 +: 2] <= 2'h0;
               o_sdram_cs[m] <= 1'b0;
               o_abort[m] <= 1'b0;
               o_ready[m] <= 1'b0;
            end else begin
               o_sel[m*3 +: 3] <= sel_d;
               o_offset[m*26 +: 26] <= off_d;
               o_cs[m*3 +: 3] <= cs_d;
               o_sram_blk[m*2 +: 2] <= off_d[15:14];
               o_sdram_cs[m] <= sdram_d;
               o_abort[m] <= abort_d;
               // Internal memories finish in the decode cycle
               o_ready[m] <= abort_d || sel_d == `MMBD_SEL_SRAM
                             || sel_d == `MMBD_SEL_ROM;
            end
         end
      end
   endgenerate
endmodule // mmbd_decoder

// ---- design/mmbd_regs.vh ----
/*
 Address map, SRAM partition codes and external chip-select defaults
 for the boot and remap address decoder. Definitions only.
*/
`ifndef MMBD_REGS_VH
`define MMBD_REGS_VH

// Slave select codes
`define MMBD_SEL_NONE 3'h0
`define MMBD_SEL_ROM 3'h1
`define MMBD_SEL_SRAM 3'h2
`define MMBD_SEL_EBI 3'h3
`define MMBD_SEL_APB 3'h4

// First level: bank number from address bits 31..28
`define MMBD_BANK_MSB 31
`define MMBD_BANK_LSB 28
`define MMBD_BANK_INT 4'h0
`define MMBD_BANK_EBI_LO 4'h1
`define MMBD_BANK_EBI_HI 4'h8
`define MMBD_BANK_APB 4'hf

// Second level inside bank 0, 1 MB areas, address bits 27..20
`define MMBD_AREA_MSB 27
`define MMBD_AREA_LSB 20
`define MMBD_AREA_BOOT 8'h00
`define MMBD_AREA_ITCM 8'h01
`define MMBD_AREA_DTCM 8'h02
`define MMBD_AREA_SRAMC 8'h03
`define MMBD_AREA_ROM 8'h04

// 16 KB block index within an area, address bits 15..14
`define MMBD_BLK_MSB 15
`define MMBD_BLK_LSB 14
`define MMBD_BLK_BITS 14

// ROM size is 32 KB, 15 offset bits
`define MMBD_ROM_BITS 15

// TCM size codes: 0, 16 KB, 32 KB
`define MMBD_TCM_0K 2'h0
`define MMBD_TCM_16K 2'h1
`define MMBD_TCM_32K 2'h2
`define MMBD_TCM_RESET 2'h0

// Number of SRAM blocks
`define MMBD_NUM_BLK 3'h4

// External chip-select defaults for boot
`define MMBD_EBI_CS_NUM 6
`define MMBD_EBI_ADDR_BITS 26
`define MMBD_CS0_BYTE_SEL_RST 1'h1
`define MMBD_CS0_WIDTH16_RST 1'h1
`define MMBD_CS0_RW_BY_CS_RST 1'h1

`endif

// ---- design/mmbd_sram_map.v ----
/*
 SRAM partition mapper: turns area, block index and TCM sizes into a
 physical 16 KB block number or a miss.
 Assumes TCM size codes stay stable during an access.
*/
`timescale 1ns/10ps
`include "mmbd_regs.vh"

module mmbd_sram_map (
   input wire [1:0] i_itcm_size,
   input wire [1:0] i_dtcm_size,
   input wire [1:0] i_area,
   input wire [1:0] i_blk,
   output reg o_hit,
   output reg [1:0] o_phys
);
   reg [2:0] i_n;
   reg [2:0] d_n;
   reg [2:0] c_n;
   reg [2:0] top;

   always @* begin
      i_n = (i_itcm_size == `MMBD_TCM_32K) ? 3'h2 :
            (i_itcm_size == `MMBD_TCM_16K) ? 3'h1 : 3'h0;
      d_n = (i_dtcm_size == `MMBD_TCM_32K) ? 3'h2 :
            (i_dtcm_size == `MMBD_TCM_16K) ? 3'h1 : 3'h0;
      c_n = `MMBD_NUM_BLK - i_n - d_n;
      top = 3'h0;
      o_hit = 1'b0;
      o_phys = 2'h0;
      case (i_area)
         2'h1: begin
            // Instruction TCM: block 1 then block 0
            o_hit = ({1'b0, i_blk} < i_n);
            o_phys = 2'h1 - i_blk;
         end
         2'h2: begin
            // Data TCM: block 3 then block 2
            o_hit = ({1'b0, i_blk} < d_n);
            o_phys = 2'h3 - i_blk;
         end
         2'h3: begin
            // AHB part: free blocks in descending order; upper pair
            // first, then whatever the instruction TCM left below it
            top = 3'h2 - d_n;
            o_hit = ({1'b0, i_blk} < c_n);
            if ({1'b0, i_blk} < top)
               o_phys = 2'h3 - d_n[1:0] - i_blk;
            else
               o_phys = 2'h3 - i_n[1:0] - d_n[1:0] - i_blk;
         end
         default: begin
            o_hit = 1'b0;
            o_phys = 2'h0;
         end
      endcase
   end
endmodule // mmbd_sram_map

// ---- verification/mmbd_decoder_props.sv ----
/*
 Checker for the boot and remap decoder, watching master 0 only.
 Assumes the decoder top ports; attached by bind from the bench top.
*/
`timescale 1ns/10ps

module mmbd_decoder_props #(
   parameter NUM_MASTERS = 6
) (
   input wire i_core_clk,
   input wire i_resetn,
   input wire [NUM_MASTERS-1:0] i_valid,
   input wire [NUM_MASTERS*32-1:0] i_addr,
   input wire [NUM_MASTERS-1:0] i_remap_set,
   input wire [NUM_MASTERS*3-1:0] o_sel,
   input wire [NUM_MASTERS*26-1:0] o_offset,
   input wire [NUM_MASTERS*3-1:0] o_cs,
   input wire [NUM_MASTERS-1:0] o_abort,
   input wire [NUM_MASTERS-1:0] o_ready,
   input wire [NUM_MASTERS-1:0] o_master_remap_bit,
   input wire o_cs0_byte_sel,
   input wire o_cs0_width16,
   input wire o_cs0_rw_by_cs
);
   wire v = i_valid[0];
   wire [3:0] bk = i_addr[31:28];
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);

   a_idle_quiet: assert property (!v |=> o_sel[2:0] == 3'h0 && !o_ready[0])
      else $error("idle master answered");
   a_abort_ready: assert property (o_abort[0] |-> o_ready[0])
      else $error("abort without ready");
   a_ebi_bank: assert property (v && bk >= 4'h1 && bk <= 4'h6 |=>
      o_sel[2:0] == 3'h3 && o_cs[2:0] == $past(i_addr[30:28]) - 3'h1
      && o_offset[25:0] == $past(i_addr[25:0]))
      else $error("external bank decode wrong");
   a_bank_abort: assert property (v && bk >= 4'h7 && bk <= 4'he |=>
      o_abort[0] && o_ready[0]) else $error("unused bank not aborted");
   a_apb_bank: assert property (v && bk == 4'hf |=>
      o_sel[2:0] == 3'h4 && !o_abort[0]) else $error("bridge bank wrong");
   a_rom_base: assert property (v && i_addr[31:15] == 17'h00080 |=>
      o_sel[2:0] == 3'h1 && o_offset[14:0] == $past(i_addr[14:0]))
      else $error("rom base decode wrong");
   a_sram_single: assert property (o_sel[2:0] == 3'h2 |->
      o_ready[0]) else $error("sram not single cycle");
   a_remap_set: assert property (i_remap_set[0] |->
      ##[1:2] o_master_remap_bit[0]) else $error("remap bit not set");
   a_cs0_boot: assert property (o_cs0_byte_sel && o_cs0_width16
      && o_cs0_rw_by_cs) else $error("cs0 boot setup lost");

   c_sram: cover property (v && bk == 4'h0 ##1 o_sel[2:0] == 3'h2);
   c_abort: cover property (o_abort[0]);
   c_remap: cover property (i_remap_set[0] ##2 o_master_remap_bit[0]);
endmodule // mmbd_decoder_props

// ---- verification/mmbd_master_model.sv ----
/*
 Six bus masters issuing random or fixed addresses each cycle.
 Assumes the bench samples requests on the rising edge.
*/
`timescale 1ns/10ps

module mmbd_master_model (
   input wire i_clk,
   input wire i_run,
   input wire i_fix,
   input wire [31:0] i_fix_addr,
   output reg [5:0] o_valid,
   output reg [191:0] o_addr
);
   integer seed;
   integer m;
   reg [31:0] r;
   initial begin
      seed = 32'hd14ff9a4;
      o_valid = 6'h0;
      o_addr = 192'h0;
   end
   // Bank 0 favoured so the internal areas see most traffic
   always @(negedge i_clk) begin
      for (m = 0; m < 6; m = m + 1) begin
         r = $random(seed);
         o_valid[m] <= i_run & (i_fix | r[31]);
         o_addr[m*32+:32] <= i_fix ? i_fix_addr :
            {r[0] ? 4'h0 : r[27:24], 5'h0, r[6:4], 4'h0, r[23:8]};
      end
   end
endmodule // mmbd_master_model

// ---- verification/tb_top.sv ----
/*
 Self-checking bench for the boot and remap decoder.
 Assumes the decoder answers one cycle after each request.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin \
   error_cnt = error_cnt + 1; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module tb_top;
   localparam [255:0] CORN = {32'h00400000, 32'h00408000, 32'h70000000,
      32'h90000000, 32'hf0000000, 32'h10000000, 32'h00300000, 32'h0};
   reg clk, resetn, boot_pin, cs1_sdram, run, fix, cap, cmp, exp_boot;
   reg sd, er, es;
   reg [5:0] rset, rclr, exp_remap, ev;
   reg [1:0] itcm, dtcm;
   reg [31:0] fix_addr;
   reg [8:0] ex [0:5];
   reg [8:0] e;
   integer ni, nd, m, j, i, d, k, error_cnt, n_checks, cyc;
   wire [5:0] valid, abort, ready, sdram_cs, remap_bit;
   wire [191:0] addr;
   wire [17:0] sel, cs;
   wire [11:0] sram_blk;
   wire boot_rom;
   wire [1:0] itsz, dtsz;

   mmbd_master_model u_mst (.i_clk(clk), .i_run(run), .i_fix(fix),
      .i_fix_addr(fix_addr), .o_valid(valid), .o_addr(addr));
   mmbd_decoder u_dut (.i_core_clk(clk), .i_resetn(resetn),
      .i_boot_select_pin(boot_pin), .i_remap_set(rset), .i_remap_clr(rclr),
      .i_itcm_size(itcm), .i_dtcm_size(dtcm), .i_cs1_sdram(cs1_sdram),
      .i_valid(valid), .i_addr(addr), .o_sel(sel), .o_offset(), .o_cs(cs),
      .o_sram_blk(sram_blk), .o_sdram_cs(sdram_cs), .o_abort(abort),
      .o_ready(ready), .o_master_remap_bit(remap_bit), .o_boot_rom(boot_rom),
      .o_itcm_size(itsz), .o_dtcm_size(dtsz), .o_cs0_byte_sel(),
      .o_cs0_width16(),
      .o_cs0_rw_by_cs());

   // Packs {abort, slave, chip select, physical block}
   function automatic [8:0] expf(input integer mi, input [31:0] a,
         input rb, input bt, input integer ic, input integer dc);
      integer bk, b, c;
      reg [2:0] s, q;
      reg [1:0] p;
      begin
         bk = a[31:28];
         b = a[15:14];
         c = 4 - ic - dc;
         s = 3'h0;
         q = 3'h0;
         p = 2'h0;
         if (bk >= 1 && bk <= 6) begin
            s = 3'h3;
            q = bk - 1;
         end else if (bk == 15) begin
            s = 3'h4;
         end else if (bk == 0 && a[27:20] == 8'h00 && !rb) begin
            s = bt ? 3'h1 : 3'h3;
         end else if (bk == 0 && a[19:16] == 4'h0) begin
            case (a[27:20])
               8'h00: if (mi >= 4 && b < c) begin
                     s = 3'h2;
                     p = (b < 2 - dc) ? 3 - dc - b : 3 - ic - dc - b;
                  end
               8'h01: if (mi != 4 && b < ic) begin
                     s = 3'h2;
                     p = 1 - b;
                  end
               8'h02: if (mi != 4 && b < dc) begin
                     s = 3'h2;
                     p = 3 - b;
                  end
               8'h03: if (b < c) begin
                     s = 3'h2;
                     p = (b < 2 - dc) ? 3 - dc - b : 3 - ic - dc - b;
                  end
               8'h04: s = {2'h0, ~a[15]};
               default: s = 3'h0;
            endcase
         end
         expf = {s == 3'h0, s, q, p};
      end
   endfunction

   task final_report;
      begin
         $display("checks %0d errors %0d", n_checks, error_cnt);
         if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   task do_reset(input b);
      begin
         run <= 1'b0;
         @(negedge clk);
         cap = 1'b0;
         resetn = 1'b0;
         boot_pin = b;
         repeat (6) @(negedge clk);
         resetn = 1'b1;
         repeat (10) @(negedge clk);
         exp_remap = 6'h0;
         exp_boot = b;
         `CHK(remap_bit, 6'h0)
         `CHK(boot_rom, b)
         cap = 1'b1;
         run <= 1'b1;
      end
   endtask

   task corners;
      for (k = 0; k < 8; k = k + 1) begin
         fix <= 1'b1;
         fix_addr <= CORN[k*32+:32];
         @(negedge clk);
         fix <= 1'b0;
      end
   endtask

   // Requests stay live during changes; only checking pauses
   task cfg(input [1:0] ic, input [1:0] dc, input [5:0] s, input [5:0] c);
      begin
         @(negedge clk);
         cap = 1'b0;
         itcm = ic;
         dtcm = dc;
         rset = s;
         rclr = c;
         @(negedge clk);
         rset = 6'h0;
         rclr = 6'h0;
         repeat (3) @(negedge clk);
         exp_remap = (exp_remap & ~c) | s;
         ni = (ic == 2'h3) ? 0 : ic;
         nd = dc;
         `CHK(remap_bit, exp_remap)
         `CHK({itsz, dtsz}, {ni[1:0], nd[1:0]})
         cap = 1'b1;
         repeat (30) @(negedge clk);
      end
   endtask

   task sweep;
      for (i = 0; i < 4; i = i + 1)
         for (d = 0; d < 3; d = d + 1)
            cfg(i[1:0], d[1:0], 6'h0, 6'h0);
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cmp <= cap;
      ev <= valid;
      sd <= cs1_sdram;
      for (m = 0; m < 6; m = m + 1)
         ex[m] <= expf(m, addr[m*32+:32], exp_remap[m], exp_boot, ni, nd);
      cyc = cyc + 1;
      if (cyc == 3000) begin
         error_cnt = error_cnt + 1;
         final_report;
      end
   end

   always @(negedge clk) if (cmp) begin
      for (j = 0; j < 6; j = j + 1) begin
         e = ex[j];
         er = ev[j] & (e[8] | e[7:5] == 3'h1 | e[7:5] == 3'h2);
         es = ev[j] & e[7:5] == 3'h3 & e[4:2] == 3'h1 & sd;
         `CHK(sel[j*3+:3], ev[j] ? e[7:5] : 3'h0)
         `CHK(abort[j], ev[j] & e[8])
         `CHK(ready[j], er)
         `CHK(sdram_cs[j], es)
         if (ev[j] && e[7:5] == 3'h3) `CHK(cs[j*3+:3], e[4:2])
         if (ev[j] && e[7:5] == 3'h2) `CHK(sram_blk[j*2+:2], e[1:0])
      end
   end

   initial begin
      resetn = 1'b0;
      boot_pin = 1'b1;
      cs1_sdram = 1'b0;
      run = 1'b0;
      fix = 1'b0;
      fix_addr = 32'h0;
      cap = 1'b0;
      cmp = 1'b0;
      rset = 6'h0;
      rclr = 6'h0;
      itcm = 2'h0;
      dtcm = 2'h0;
      exp_remap = 6'h0;
      exp_boot = 1'b1;
      ni = 0;
      nd = 0;
      error_cnt = 0;
      n_checks = 0;
      cyc = 0;
      do_reset(1'b1);
      corners;
      boot_pin = 1'b0;
      sweep;
      cs1_sdram = 1'b1;
      cfg(2'h0, 2'h0, 6'h21, 6'h0);
      corners;
      sweep;
      do_reset(1'b0);
      corners;
      cfg(2'h1, 2'h1, 6'h30, 6'h10);
      corners;
      cfg(2'h0, 2'h0, 6'h0, 6'h20);
      final_report;
   end
endmodule // tb_top

bind mmbd_decoder mmbd_decoder_props #(.NUM_MASTERS(NUM_MASTERS)) u_props (
   .i_core_clk, .i_resetn, .i_valid, .i_addr, .i_remap_set, .o_sel,
   .o_offset, .o_cs, .o_abort, .o_ready, .o_master_remap_bit,
   .o_cs0_byte_sel, .o_cs0_width16, .o_cs0_rw_by_cs);
